/* pkg/ptt_pkg.sv */
// Package for the periodic tick timer: register map, fields, resets
package ptt_pkg;
  // Register offsets on the plain register port
  localparam logic [7:0] ADDR_CTRL_STATUS = 8'h4b;
  localparam logic [7:0] ADDR_CNT_HIGH = 8'h4c;
  localparam logic [7:0] ADDR_CNT_LOW = 8'h4d;
  localparam logic [7:0] ADDR_MOD_HIGH = 8'h4e;
  localparam logic [7:0] ADDR_MOD_LOW = 8'h4f;
  // Control/status field positions
  localparam int unsigned FLAG_BIT = 7;
  localparam int unsigned IRQ_EN_BIT = 6;
  localparam int unsigned HALT_BIT = 5;
  localparam int unsigned CLEAR_BIT = 4;
  localparam int unsigned PS_MSB = 2;
  // Reset values
  localparam logic [15:0] MOD_RESET = 16'hffff;
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [2:0] PS_RESET = 3'h0;
  localparam logic HALT_RESET = 1'b1;
  // Prescaler: divide codes 0..6 map to 2**code, code 7 same as 6
  localparam logic [2:0] PS_MAX_CODE = 3'h6;
  localparam int unsigned PS_WIDTH = 6;

  typedef struct packed {
    logic flag;
    logic irq_en;
    logic halt;
    logic [2:0] ps_sel;
  } ptt_ctrl_s;

  typedef enum logic [1:0] {
    CLR_IDLE = 2'b00,
    CLR_ARMED = 2'b01
  } ptt_clr_e;
endpackage

/* hw/ptt_timer.sv */
// Periodic tick timer: prescaler, modulo counter and register file
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
module ptt_timer (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic break_i,
  output logic [7:0] rdata_o,
  output logic irq_o
);

  ptt_pkg::ptt_ctrl_s ctrl_q;
  logic [15:0] cnt_q;
  logic [15:0] mod_q;
  logic [5:0] pre_q;
  logic clear_q;
  logic [7:0] low_latch_q;
  logic latched_q;
  logic inhibit_q;
  ptt_pkg::ptt_clr_e clr_state_q;
  logic tick;
  logic match;
  logic overflow;
  logic [5:0] pre_mask;
  logic wr_cs;
  logic clear_req;

  //////////////////////////////////////////////////////////////////////////
  // Prescaler and counter

  assign wr_cs = wr_i && (addr_i == ptt_pkg::ADDR_CTRL_STATUS);
  assign clear_req = wr_cs && wdata_i[ptt_pkg::CLEAR_BIT];

  // Code 7 aliases code 6, so the mask saturates at six bits
  always_comb
  begin
    if (ctrl_q.ps_sel >= ptt_pkg::PS_MAX_CODE)
      pre_mask = 6'h3f;
    else
      pre_mask = 6'((7'h01 << ctrl_q.ps_sel) - 7'h01);
  end

  assign tick = ((pre_q & pre_mask) == pre_mask) && !ctrl_q.halt
                && !break_i;
  assign match = (cnt_q == mod_q);
  assign overflow = tick && match && !clear_q;

  // Prescaler runs only while counting, so halt freezes the phase too
  always_ff @(posedge ref_clk_i)
  begin
    if (!rstn_i || clear_q)
      pre_q <= 6'h00;
    else if (!ctrl_q.halt && !break_i)
      pre_q <= pre_q + 6'h01;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rstn_i || clear_q)
      cnt_q <= ptt_pkg::CNT_RESET;
    else if (tick)
    begin
      if (match)
        cnt_q <= ptt_pkg::CNT_RESET;
      else
        cnt_q <= cnt_q + 16'h0001;
    end
  end

  // Clear acts one cycle after the write, then drops by itself
  always_ff @(posedge ref_clk_i)
  begin
    if (!rstn_i)
      clear_q <= 1'b0;
    else
      clear_q <= clear_req;
  end

  //////////////////////////////////////////////////////////////////////////
  // Control, flag and clearing sequence

  always_ff @(posedge ref_clk_i)
  begin
    if (!rstn_i)
    begin
      ctrl_q.irq_en <= 1'b0;
      ctrl_q.halt <= ptt_pkg::HALT_RESET;
      ctrl_q.ps_sel <= ptt_pkg::PS_RESET;
    end
    else if (wr_cs)
    begin
      ctrl_q.irq_en <= wdata_i[ptt_pkg::IRQ_EN_BIT];
      ctrl_q.halt <= wdata_i[ptt_pkg::HALT_BIT];
      ctrl_q.ps_sel <= wdata_i[ptt_pkg::PS_MSB:0];
    end
  end

  // Arming on a status read seen while the flag stands
  always_ff @(posedge ref_clk_i)
  begin
    if (!rstn_i)
      clr_state_q <= ptt_pkg::CLR_IDLE;
    else if (overflow && !inhibit_q)
      clr_state_q <= ptt_pkg::CLR_IDLE;
    else if (rd_i && addr_i == ptt_pkg::ADDR_CTRL_STATUS && ctrl_q.flag)
      clr_state_q <= ptt_pkg::CLR_ARMED;
    else if (wr_cs)
      clr_state_q <= ptt_pkg::CLR_IDLE;
  end

  // A fresh overflow wins over the clearing write
  always_ff @(posedge ref_clk_i)
  begin
    if (!rstn_i)
      ctrl_q.flag <= 1'b0;
    else if (overflow && !inhibit_q)
      ctrl_q.flag <= 1'b1;
    else if (wr_cs && !wdata_i[ptt_pkg::FLAG_BIT]
             && clr_state_q == ptt_pkg::CLR_ARMED)
      ctrl_q.flag <= 1'b0;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rstn_i)
      irq_o <= 1'b0;
    else
      irq_o <= ctrl_q.flag && ctrl_q.irq_en;
  end

  //////////////////////////////////////////////////////////////////////////
  // Modulo registers

  always_ff @(posedge ref_clk_i)
  begin
    if (!rstn_i)
      mod_q <= ptt_pkg::MOD_RESET;
    else if (wr_i && addr_i == ptt_pkg::ADDR_MOD_HIGH)
      mod_q[15:8] <= wdata_i;
    else if (wr_i && addr_i == ptt_pkg::ADDR_MOD_LOW)
      mod_q[7:0] <= wdata_i;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rstn_i)
      inhibit_q <= 1'b0;
    else if (wr_i && addr_i == ptt_pkg::ADDR_MOD_HIGH)
      inhibit_q <= 1'b1;
    else if (wr_i && addr_i == ptt_pkg::ADDR_MOD_LOW)
      inhibit_q <= 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////
  // Counter read latch

  always_ff @(posedge ref_clk_i)
  begin
    if (!rstn_i || clear_q)
    begin
      low_latch_q <= 8'h00;
      latched_q <= 1'b0;
    end
    else if (rd_i && addr_i == ptt_pkg::ADDR_CNT_HIGH && !latched_q)
    begin
      low_latch_q <= cnt_q[7:0];
      latched_q <= 1'b1;
    end
    else if (rd_i && addr_i == ptt_pkg::ADDR_CNT_LOW)
      latched_q <= 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////
  // Read data; counter bytes take no writes, unmapped reads give zero

  always_ff @(posedge ref_clk_i)
  begin
    if (!rstn_i)
      rdata_o <= 8'h00;
    else if (rd_i)
    begin
      unique case (addr_i)
        ptt_pkg::ADDR_CTRL_STATUS:
          rdata_o <= {ctrl_q.flag, ctrl_q.irq_en, ctrl_q.halt, 2'b00,
                      ctrl_q.ps_sel};
        ptt_pkg::ADDR_CNT_HIGH: rdata_o <= cnt_q[15:8];
        ptt_pkg::ADDR_CNT_LOW:
          rdata_o <= latched_q ? low_latch_q : cnt_q[7:0];
        ptt_pkg::ADDR_MOD_HIGH: rdata_o <= mod_q[15:8];
        ptt_pkg::ADDR_MOD_LOW: rdata_o <= mod_q[7:0];
        default: rdata_o <= 8'h00;
      endcase
    end
    else
      rdata_o <= 8'h00;
  end

  //////////////////////////////////////////////////////////////////////////
  // Checks

  chk_halt_freeze: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    ctrl_q.halt && !clear_q |=> cnt_q == $past(cnt_q))
    else $error("counter moved while halted");
  chk_clear_zero: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    clear_req |-> ##2 cnt_q == 16'h0000)
    else $error("clear did not zero counter");
  chk_clear_self: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    clear_q |=> !clear_q || $past(clear_req))
    else $error("clear bit stuck");
  chk_flag_set: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    overflow && !inhibit_q |=> ctrl_q.flag && cnt_q == 16'h0000)
    else $error("overflow missed");
  chk_inhibit_hold: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    inhibit_q && !ctrl_q.flag |=> !ctrl_q.flag)
    else $error("flag set while inhibited");
  chk_flag_no_clr: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    ctrl_q.flag && clr_state_q == ptt_pkg::CLR_IDLE |=> ctrl_q.flag)
    else $error("flag cleared without read");
  chk_irq_follow: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    ##1 irq_o == $past(ctrl_q.flag && ctrl_q.irq_en))
    else $error("irq mismatch");
  chk_break_stop: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    break_i && !clear_q |=> $stable(cnt_q))
    else $error("counted in break");
  chk_count_step: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    tick && !match && !clear_q |=> cnt_q == $past(cnt_q) + 16'h0001)
    else $error("bad count step");
  chk_clear_reads0: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    rd_i && addr_i == ptt_pkg::ADDR_CTRL_STATUS |=> rdata_o[4:3] == 2'b00)
    else $error("clear bit read as one");
  chk_flag_one_wr: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    wr_cs && wdata_i[7] && !ctrl_q.flag && !overflow |=> !ctrl_q.flag)
    else $error("flag set by write");
  chk_halt_resume: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    !ctrl_q.halt && !break_i && !clear_q && pre_mask == 6'h00 && !match
    |=> cnt_q == $past(cnt_q) + 16'h0001)
    else $error("counter not running");
  chk_clear_pre: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    clear_q |=> pre_q == 6'h00)
    else $error("prescaler not cleared");
  chk_clear_keeps: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    clear_q && !wr_i |=> $stable(mod_q) && $stable(ctrl_q.irq_en))
    else $error("clear touched other registers");
  chk_clear_drop: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    !clear_req |=> !clear_q)
    else $error("clear without write");
  chk_halt_clear_zero: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    ctrl_q.halt && clear_q && !wr_cs |=> cnt_q == 16'h0000 ##1 cnt_q == 16'h0000)
    else $error("halted clear not held at zero");
  chk_ps_alias: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    ctrl_q.ps_sel == 3'h7 |-> pre_mask == 6'h3f)
    else $error("code seven not divide by 64");
  chk_tick_rate: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    tick && ctrl_q.ps_sel == 3'h1 && !wr_cs |=> !tick)
    else $error("divide by two ticked twice");
  chk_cnt_ro: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    wr_i && (addr_i == ptt_pkg::ADDR_CNT_HIGH || addr_i == ptt_pkg::ADDR_CNT_LOW)
    && !tick && !clear_q |=> $stable(cnt_q))
    else $error("counter took a write");
  chk_latch_take: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    rd_i && addr_i == ptt_pkg::ADDR_CNT_HIGH && !latched_q && !clear_q
    |=> latched_q && low_latch_q == $past(cnt_q[7:0]))
    else $error("low byte not latched");
  chk_latch_keep: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    latched_q && !(rd_i && addr_i == ptt_pkg::ADDR_CNT_LOW) && !clear_q
    |=> latched_q && $stable(low_latch_q))
    else $error("latched low byte lost");
  chk_low_from_latch: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    rd_i && addr_i == ptt_pkg::ADDR_CNT_LOW && latched_q
    |=> rdata_o == $past(low_latch_q))
    else $error("low read not from latch");
  chk_high_read: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    rd_i && addr_i == ptt_pkg::ADDR_CNT_HIGH |=> rdata_o == $past(cnt_q[15:8]))
    else $error("bad high byte read");
  chk_read_calm: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    rd_i && !tick && !clear_q |=> $stable(cnt_q))
    else $error("read disturbed counter");
  chk_rollover: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    tick && match && !clear_q |=> cnt_q == 16'h0000)
    else $error("no rollover to zero");
  chk_inhibit_set: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    wr_i && addr_i == ptt_pkg::ADDR_MOD_HIGH |=> inhibit_q)
    else $error("high write did not inhibit");
  chk_mod_write: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    wr_i && addr_i == ptt_pkg::ADDR_MOD_LOW |=> mod_q[7:0] == $past(wdata_i))
    else $error("modulo low not written");
  chk_irq_low: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    !ctrl_q.irq_en |=> !irq_o)
    else $error("irq while disabled");
  chk_flag_clear: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    wr_cs && !wdata_i[7] && clr_state_q == ptt_pkg::CLR_ARMED && !overflow
    |=> !ctrl_q.flag)
    else $error("armed clear ignored");
  chk_race_keep: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    overflow && !inhibit_q |=> clr_state_q == ptt_pkg::CLR_IDLE)
    else $error("overflow left clear armed");

  cov_overflow: cover property (@(posedge ref_clk_i) overflow);
  cov_clear_seq: cover property (@(posedge ref_clk_i)
    clr_state_q == ptt_pkg::CLR_ARMED ##1 !ctrl_q.flag);
  cov_race: cover property (@(posedge ref_clk_i)
    clr_state_q == ptt_pkg::CLR_ARMED && overflow && wr_cs);
  cov_latch: cover property (@(posedge ref_clk_i) latched_q ##1 !latched_q);

endmodule

/* tb/ptt_timer_tb_top.sv */
// Self-checking bench for the periodic tick timer
`timescale 1ns/1ps
module ptt_timer_tb_top;
  logic ref_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic break_i = 1'b0;
  logic [7:0] rdata_o;
  logic irq_o;
  logic [31:0] lfsr = 32'h04b6;
  logic [7:0] q;
  logic [7:0] keep;
  logic [15:0] v;
  logic [15:0] e;
  int divs[$] = '{1, 2, 4, 8, 16, 32, 64, 64};
  int bad_count = 0;
  int total_checks = 0;
  int i;
  int n;

  ptt_timer i_ptt_timer (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .addr_i(addr_i),
    .wdata_i(wdata_i),
    .wr_i(wr_i),
    .rd_i(rd_i),
    .break_i(break_i),
    .rdata_o(rdata_o),
    .irq_o(irq_o)
  );

  always #5 ref_clk_i = ~ref_clk_i;

  //////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] step(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input string w, input logic [15:0] x,
    input logic [15:0] s);
    total_checks++;
    if (x !== s)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", w, x, s);
    end
  endtask

  // One strobe cycle, then a gap so no signal is driven twice per edge
  task automatic bus(input logic [7:0] a, input logic [7:0] d,
    input logic w);
    @(posedge ref_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= w;
    rd_i <= !w;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
    rd_i <= 1'b0;
    #1;
    q = rdata_o;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    bus(a, 8'h00, 1'b0);
    check($sformatf("reg %h", a), {8'h00, x}, {8'h00, q});
  endtask

  task automatic wst(input logic [7:0] d);
    bus(ptt_pkg::ADDR_CTRL_STATUS, d, 1'b1);
  endtask

  task automatic rdcnt();
    bus(ptt_pkg::ADDR_CNT_HIGH, 8'h00, 1'b0);
    v[15:8] = q;
    bus(ptt_pkg::ADDR_CNT_LOW, 8'h00, 1'b0);
    v[7:0] = q;
  endtask

  task automatic wmod(input logic [15:0] m);
    bus(ptt_pkg::ADDR_MOD_HIGH, m[15:8], 1'b1);
    bus(ptt_pkg::ADDR_MOD_LOW, m[7:0], 1'b1);
  endtask

  task automatic wait_irq();
    for (i = 0; i < 40 && irq_o !== 1'b1; i++)
      @(posedge ref_clk_i);
    check("irq", 16'h0001, {15'h0000, irq_o});
  endtask

  //////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (12) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    rd(ptt_pkg::ADDR_CTRL_STATUS, 8'h20);
    rdcnt();
    check("cnt", 16'h0000, v);
    rd(ptt_pkg::ADDR_MOD_HIGH, 8'hff);
    rd(ptt_pkg::ADDR_MOD_LOW, 8'hff);
    for (n = 0; n < 4; n++)
    begin
      lfsr = step(lfsr);
      wmod(lfsr[15:0]);
      rd(ptt_pkg::ADDR_MOD_HIGH, lfsr[15:8]);
      rd(ptt_pkg::ADDR_MOD_LOW, lfsr[7:0]);
      bus(ptt_pkg::ADDR_CNT_HIGH, lfsr[23:16], 1'b1);
      bus(ptt_pkg::ADDR_CNT_LOW, lfsr[31:24], 1'b1);
      rdcnt();
      check("cnt", 16'h0000, v);
      rd({4'h6, lfsr[3:0]}, 8'h00);
    end
    wmod(16'h0003);
    wst(8'h50);
    wait_irq();
    rd(ptt_pkg::ADDR_CTRL_STATUS, 8'hc0);
    repeat (6) @(posedge ref_clk_i);
    wst(8'h40);
    rd(ptt_pkg::ADDR_CTRL_STATUS, 8'hc0);
    wst(8'he0);
    wst(8'h60);
    rd(ptt_pkg::ADDR_CTRL_STATUS, 8'he0);
    wst(8'h60);
    rd(ptt_pkg::ADDR_CTRL_STATUS, 8'h60);
    repeat (2) @(posedge ref_clk_i);
    check("irq", 16'h0000, {15'h0000, irq_o});
    bus(ptt_pkg::ADDR_MOD_HIGH, 8'h00, 1'b1);
    wst(8'h40);
    repeat (20) @(posedge ref_clk_i);
    rd(ptt_pkg::ADDR_CTRL_STATUS, 8'h40);
    check("irq", 16'h0000, {15'h0000, irq_o});
    bus(ptt_pkg::ADDR_MOD_LOW, 8'h03, 1'b1);
    wait_irq();
    rdcnt();
    check("wrap", 16'h0001, {15'h0000, v < 16'h0004});
    wst(8'hf0);
    repeat (4) @(posedge ref_clk_i);
    rdcnt();
    check("cnt", 16'h0000, v);
    rd(ptt_pkg::ADDR_CTRL_STATUS, 8'he0);
    wmod(16'hffff);
    @(posedge ref_clk_i);
    break_i <= 1'b1;
    wst(8'h90);
    repeat (50) @(posedge ref_clk_i);
    wst(8'hb0);
    rdcnt();
    check("cnt", 16'h0000, v);
    @(posedge ref_clk_i);
    break_i <= 1'b0;
    for (n = 0; n < 8; n++)
    begin
      wst(8'h90 | n[7:0]);
      repeat (510) @(posedge ref_clk_i);
      wst(8'ha0 | n[7:0]);
      rdcnt();
      e = 16'(512 / divs[n]);
      // Slack of two covers prescaler phase at start and stop
      check("count", e, (v - e + 16'h0002) <= 16'h0004 ? e : v);
    end
    keep = v[7:0];
    bus(ptt_pkg::ADDR_CNT_HIGH, 8'h00, 1'b0);
    wst(8'h80);
    repeat (300) @(posedge ref_clk_i);
    wst(8'ha0);
    bus(ptt_pkg::ADDR_CNT_HIGH, 8'h00, 1'b0);
    rd(ptt_pkg::ADDR_CNT_LOW, keep);
    close_out();
  end

  initial
  begin
    repeat (20000) @(posedge ref_clk_i);
    bad_count++;
    close_out();
  end
endmodule
